// File: pkg/ibc_pkg.sv
/*
 * Shared constants and types of the bridge command sequencer: command codes,
 * register selectors, reset values, sequencer states and carrier structs.
 * Assumes that every user writes ibc_pkg::name and imports nothing.
 */
package ibc_pkg;

    // Command codes taken as the first byte of a write access.
    localparam logic [7:0] CMD_BRIDGE_RESET = 8'hF0;
    localparam logic [7:0] CMD_POINTER_SELECT = 8'hE1;
    localparam logic [7:0] CMD_CONFIG_WRITE = 8'hD2;
    localparam logic [7:0] CMD_LINE_RESET = 8'hB4;
    localparam logic [7:0] CMD_LINE_SINGLE_BIT = 8'h87;
    localparam logic [7:0] CMD_LINE_WRITE_BYTE = 8'hA5;
    localparam logic [7:0] CMD_LINE_READ_BYTE = 8'h96;
    localparam logic [7:0] CMD_SEARCH_TRIPLET = 8'h78;

    // Read pointer selectors.
    localparam logic [7:0] SEL_STATUS = 8'hF0;
    localparam logic [7:0] SEL_READ_DATA = 8'hE1;
    localparam logic [7:0] SEL_CONFIG = 8'hC3;

    // Reset values, bit count per byte and write byte indices.
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PARAM_NONE = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] IDX_CMD = 2'h0;
    localparam logic [1:0] IDX_PARAM = 2'h1;
    localparam logic [1:0] IDX_EXTRA = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK,
        S_TX,
        S_MACK
    } ibc_state_e;

    // One request to the downstream line engine.
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] param;
    } ibc_line_req_s;

    // Bus events seen by the front end, all one-cycle pulses except sda.
    typedef struct packed {
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic sda;
    } ibc_bus_ev_s;

endpackage

// File: src/ibc_bus_front.sv
/*
 * Serial bus front end: synchronises clock, data and address pins and
 * reports clock edges and start and stop conditions as one-cycle pulses.
 * Assumes the system clock is far faster than the serial clock.
 */
`timescale 1ns/1ps

module ibc_bus_front (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [1:0] addr_pins,
    output ibc_pkg::ibc_bus_ev_s ev,
    output logic [1:0] addr_s
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic [1:0] addr_meta;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;

    // The clock pin is only ever sampled; nothing here can hold it low.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            addr_meta <= 2'h0;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            addr_s <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_i};
            sda_meta <= {sda_meta[0], sda_i};
            addr_meta <= addr_pins;
            scl_s <= scl_meta[1];
            sda_s <= sda_meta[1];
            addr_s <= addr_meta;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign ev.rise = scl_s && !scl_d;
    assign ev.fall = !scl_s && scl_d;
    assign ev.start = scl_s && scl_d && sda_d && !sda_s;
    assign ev.stop = scl_s && scl_d && !sda_d && sda_s;
    assign ev.sda = sda_s;

endmodule

// File: src/ibc_sequencer.sv
/*
 * Command sequencer of the serial-bus bridge: a byte-level bus slave that
 * decodes commands, keeps the read pointer and configuration byte, and
 * hands line requests to the downstream line engine.
 * Assumes the line engine raises line_busy_flag within a cycle of a request
 * and drives its status and read data on the same clock.
 */
`timescale 1ns/1ps

// Functional notes
// - Pointer select C3h acknowledged, selects configuration.
// - Undefined pointer selector byte is not acknowledged.
// - Line commands refused while line busy.
// - Every status byte carries the current busy flag.
// - Line reset outcome stands in status.
// - Selector E1h makes reads return line data.
// - Pointer select accepted while line is busy.
// - Triplet takes one parameter; outcome in status.
// - Serial clock is input only, never stretched.
// - Command codes decoded to fixed values.
// - Only valid commands and parameters are acknowledged.
// - Read pointer persists until the next select, configuration write or bridge reset.
module ibc_sequencer #(
    parameter int ADDR_HI = 12
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] addr_pins,
    input wire logic line_busy_flag,
    input wire logic [7:0] status_in,
    input wire logic [7:0] read_data_in,
    output logic line_req_valid,
    output ibc_pkg::ibc_line_req_s line_req,
    output logic bridge_reset_pulse,
    output logic [7:0] config_byte
);
    if (ADDR_HI < 0 || ADDR_HI > 31) begin : g_bad_addr
        $error("ADDR_HI must fit in five bits");
    end

    localparam logic [4:0] ADDR_TOP = 5'(ADDR_HI);

    function automatic logic sel_valid(input logic [7:0] b);
        sel_valid = (b == ibc_pkg::SEL_STATUS) || (b == ibc_pkg::SEL_READ_DATA)
            || (b == ibc_pkg::SEL_CONFIG);
    endfunction

    // Busy refusal applies to every command that starts line activity.
    function automatic logic wr_decide(input logic [1:0] idx, input logic [7:0] code,
                                       input logic [7:0] b, input logic busy);
        logic ok;
        ok = 1'b0;
        if (idx == ibc_pkg::IDX_CMD) begin
            case (b)
                ibc_pkg::CMD_BRIDGE_RESET, ibc_pkg::CMD_POINTER_SELECT: ok = 1'b1;
                ibc_pkg::CMD_CONFIG_WRITE, ibc_pkg::CMD_LINE_RESET,
                ibc_pkg::CMD_LINE_SINGLE_BIT, ibc_pkg::CMD_LINE_WRITE_BYTE,
                ibc_pkg::CMD_LINE_READ_BYTE, ibc_pkg::CMD_SEARCH_TRIPLET: ok = !busy;
                default: ok = 1'b0;
            endcase
        end else if (idx == ibc_pkg::IDX_PARAM) begin
            case (code)
                ibc_pkg::CMD_POINTER_SELECT: ok = sel_valid(b);
                ibc_pkg::CMD_CONFIG_WRITE, ibc_pkg::CMD_LINE_SINGLE_BIT,
                ibc_pkg::CMD_LINE_WRITE_BYTE, ibc_pkg::CMD_SEARCH_TRIPLET: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        wr_decide = ok;
    endfunction

    ibc_pkg::ibc_bus_ev_s ev;
    logic [1:0] addr_s;
    ibc_pkg::ibc_state_e state;
    ibc_pkg::ibc_state_e next_state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic addr_phase;
    logic rw;
    logic [1:0] wr_idx;
    logic [7:0] cmd;
    logic [7:0] ptr;

    ibc_bus_front u_front (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_pins(addr_pins),
        .ev(ev),
        .addr_s(addr_s)
    );

    wire byte_done = (state == ibc_pkg::S_RX) && (bitcnt == ibc_pkg::BITS_PER_BYTE) && ev.fall;
    wire addr_hit = (shift[7:1] == {ADDR_TOP, addr_s});
    wire take_wr = byte_done && !addr_phase;
    wire wr_ack = wr_decide(wr_idx, cmd, shift, line_busy_flag);
    wire ack_now = addr_phase ? addr_hit : wr_ack;
    wire accept = take_wr && wr_ack;
    wire at_cmd = (wr_idx == ibc_pkg::IDX_CMD);
    wire at_param = (wr_idx == ibc_pkg::IDX_PARAM);
    wire do_reset = accept && at_cmd && (shift == ibc_pkg::CMD_BRIDGE_RESET);
    wire launch_plain = accept && at_cmd && ((shift == ibc_pkg::CMD_LINE_RESET)
        || (shift == ibc_pkg::CMD_LINE_READ_BYTE));
    wire launch_param = accept && at_param && ((cmd == ibc_pkg::CMD_LINE_SINGLE_BIT)
        || (cmd == ibc_pkg::CMD_LINE_WRITE_BYTE) || (cmd == ibc_pkg::CMD_SEARCH_TRIPLET));
    wire sel_load = accept && at_param && (cmd == ibc_pkg::CMD_POINTER_SELECT);
    wire cfg_load = accept && at_param && (cmd == ibc_pkg::CMD_CONFIG_WRITE);
    wire tx_load = (state == ibc_pkg::S_ACK && ev.fall && rw)
        || (state == ibc_pkg::S_MACK && ev.fall);
    wire tx_last = (state == ibc_pkg::S_TX) && ev.fall && (bitcnt == ibc_pkg::BITS_PER_BYTE);

    // The busy flag is sampled at every status byte load, so a poll loop sees it fall.
    wire [7:0] status_byte = {status_in[7:1], line_busy_flag};
    wire [7:0] tx_byte = (ptr == ibc_pkg::SEL_READ_DATA) ? read_data_in
        : (ptr == ibc_pkg::SEL_CONFIG) ? config_byte : status_byte;

    // A refused byte drops the slave to idle; only a new start revives it.
    always_comb begin
        next_state = state;
        if (ev.stop) begin
            next_state = ibc_pkg::S_IDLE;
        end else if (ev.start) begin
            next_state = ibc_pkg::S_RX;
        end else begin
            unique case (state)
                ibc_pkg::S_IDLE: next_state = ibc_pkg::S_IDLE;
                ibc_pkg::S_RX: begin
                    if (byte_done) begin
                        next_state = ack_now ? ibc_pkg::S_ACK : ibc_pkg::S_IDLE;
                    end
                end
                ibc_pkg::S_ACK: begin
                    if (ev.fall) begin
                        next_state = rw ? ibc_pkg::S_TX : ibc_pkg::S_RX;
                    end
                end
                ibc_pkg::S_TX: begin
                    if (tx_last) begin
                        next_state = ibc_pkg::S_MACK;
                    end
                end
                ibc_pkg::S_MACK: begin
                    if (ev.rise && ev.sda) begin
                        next_state = ibc_pkg::S_IDLE;
                    end else if (ev.fall) begin
                        next_state = ibc_pkg::S_TX;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ibc_pkg::S_IDLE;
            bitcnt <= 4'h0;
            shift <= 8'h00;
        end else begin
            state <= next_state;
            if (ev.start || (state == ibc_pkg::S_ACK && ev.fall) || tx_load) begin
                bitcnt <= 4'h0;
            end else if (ev.rise && (state == ibc_pkg::S_RX || state == ibc_pkg::S_TX)) begin
                bitcnt <= bitcnt + 4'h1;
            end
            if (tx_load) begin
                shift <= tx_byte;
            end else if (state == ibc_pkg::S_RX && ev.rise) begin
                shift <= {shift[6:0], ev.sda};
            end else if (state == ibc_pkg::S_TX && ev.fall && !tx_last) begin
                shift <= {shift[6:0], 1'b0};
            end
        end
    end

    // Open drain: the pin is only ever pulled low, and only by the enable.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else if (ev.start || ev.stop) begin
            sda_oe <= 1'b0;
        end else if (byte_done) begin
            sda_oe <= ack_now;
        end else if (tx_load) begin
            sda_oe <= !tx_byte[7];
        end else if (state == ibc_pkg::S_ACK && ev.fall) begin
            sda_oe <= 1'b0;
        end else if (state == ibc_pkg::S_TX && ev.fall) begin
            sda_oe <= tx_last ? 1'b0 : !shift[6];
        end
    end

    assign sda_o = 1'b0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_phase <= 1'b0;
            rw <= 1'b0;
            wr_idx <= ibc_pkg::IDX_CMD;
            cmd <= 8'h00;
        end else if (ev.start) begin
            addr_phase <= 1'b1;
            wr_idx <= ibc_pkg::IDX_CMD;
        end else if (byte_done) begin
            addr_phase <= 1'b0;
            rw <= addr_phase ? shift[0] : rw;
            wr_idx <= (addr_phase || wr_idx == ibc_pkg::IDX_EXTRA) ? wr_idx : wr_idx + 2'h1;
            cmd <= (take_wr && at_cmd) ? shift : cmd;
        end
    end

    // Pointer and configuration change only on an accepted write.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= ibc_pkg::SEL_STATUS;
            config_byte <= ibc_pkg::CONFIG_RESET;
        end else if (do_reset) begin
            ptr <= ibc_pkg::SEL_STATUS;
            config_byte <= ibc_pkg::CONFIG_RESET;
        end else if (sel_load) begin
            ptr <= shift;
        end else if (cfg_load) begin
            ptr <= ibc_pkg::SEL_CONFIG;
            config_byte <= shift;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_req_valid <= 1'b0;
            bridge_reset_pulse <= 1'b0;
            line_req <= '0;
        end else begin
            line_req_valid <= launch_plain || launch_param;
            bridge_reset_pulse <= do_reset;
            if (launch_plain) begin
                line_req <= {shift, ibc_pkg::PARAM_NONE};
            end else if (launch_param) begin
                line_req <= {cmd, shift};
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    cfg_select_a: assert property (accept && at_param && cmd == ibc_pkg::CMD_POINTER_SELECT
        && shift == ibc_pkg::SEL_CONFIG |=> sda_oe && ptr == ibc_pkg::SEL_CONFIG)
        else $error("Configuration selector not taken.");
    bad_selector_a: assert property (take_wr && at_param
        && cmd == ibc_pkg::CMD_POINTER_SELECT && !sel_valid(shift) |=> !sda_oe ##1 !sda_oe)
        else $error("Undefined selector acknowledged.");
    busy_refuse_a: assert property (take_wr && at_cmd && line_busy_flag
        && (shift == ibc_pkg::CMD_LINE_READ_BYTE || shift == ibc_pkg::CMD_SEARCH_TRIPLET
        || shift == ibc_pkg::CMD_CONFIG_WRITE || shift == ibc_pkg::CMD_LINE_RESET)
        |=> !sda_oe && !line_req_valid && state == ibc_pkg::S_IDLE)
        else $error("Line command acknowledged while busy.");
    busy_poll_a: assert property (tx_load && ptr == ibc_pkg::SEL_STATUS
        |=> shift[0] == $past(line_busy_flag) && sda_oe == !shift[7])
        else $error("Status byte lost the busy flag.");
    reset_launch_a: assert property (take_wr && at_cmd && !line_busy_flag
        && shift == ibc_pkg::CMD_LINE_RESET |=> line_req_valid
        && line_req.code == ibc_pkg::CMD_LINE_RESET ##1 !line_req_valid)
        else $error("Line reset not launched as one pulse.");
    data_select_a: assert property (tx_load && ptr == ibc_pkg::SEL_READ_DATA
        |=> shift == $past(read_data_in))
        else $error("Read data not returned.");
    select_busy_a: assert property (take_wr && at_cmd
        && shift == ibc_pkg::CMD_POINTER_SELECT |=> sda_oe && state == ibc_pkg::S_ACK)
        else $error("Pointer select refused.");
    triplet_param_a: assert property (accept && at_param
        && cmd == ibc_pkg::CMD_SEARCH_TRIPLET |=> line_req_valid
        && line_req.param == $past(shift))
        else $error("Triplet parameter not passed.");
    reset_decode_a: assert property (take_wr && at_cmd
        && shift == ibc_pkg::CMD_BRIDGE_RESET |=> bridge_reset_pulse && sda_oe)
        else $error("Bridge reset not decoded.");
    extra_nack_a: assert property (take_wr && wr_idx == ibc_pkg::IDX_EXTRA
        |=> !sda_oe)
        else $error("Extra byte acknowledged.");
    ptr_hold_a: assert property (!(sel_load || cfg_load || do_reset) |=> $stable(ptr))
        else $error("Read pointer changed without a command.");
    addr_miss_a: assert property (byte_done && addr_phase && !addr_hit
        |=> !sda_oe && state == ibc_pkg::S_IDLE)
        else $error("Foreign address acknowledged.");

endmodule

// File: bench/ibc_host_model.sv
/*
 * Host model that masters the serial bus of the bridge: start, stop, byte
 * write and byte read with acknowledge, all timed from the system clock.
 * Assumes the bench resolves the data line as a wired AND with a pull-up.
 */
`timescale 1ns/1ps

module ibc_host_model #(
    parameter int HALF = 10
) (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // The clock is driven push-pull and never waits on the line.
    task automatic start();
        sda_low <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
        tick(HALF);
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b0;
        tick(HALF);
    endtask

    // Data moves two cycles after the clock falls, so no false start is seen.
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF / 2);
        r = sda_line;
        tick(HALF - HALF / 2);
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic read_byte(output logic [7:0] b, input logic m_ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(~m_ack, r);
    endtask
endmodule

// File: bench/i2c_bridge_command_sequencer_tb.sv
/*
 * Self-checking bench of the bridge command sequencer with a host model on
 * the serial bus and a small line engine model on the downstream side.
 * Assumes the design's own assertions run alongside.
 */
`timescale 1ns/1ps

module i2c_bridge_command_sequencer_tb;
    localparam logic [4:0] ADDR_HI = 5'h0C;
    localparam logic [1:0] PINS = 2'h2;
    localparam logic [7:0] STAT = 8'hA6;
    localparam logic [7:0] RDATA = 8'h3B;
    logic clk_sys, rst_n, scl, m_low, sda_oe, sda_o, req_valid, rst_pulse;
    logic busy = 1'b0;
    logic [7:0] config_byte, status_in, read_data_in;
    logic [1:0] addr_pins;
    ibc_pkg::ibc_line_req_s line_req;
    ibc_pkg::ibc_line_req_s last_req = '0;
    int n_errors = 0, cmp_count = 0, n_req = 0, n_rst = 0, busy_len = 100, busy_cnt = 0;
    wire sda_line = ~m_low & (sda_oe ? sda_o : 1'b1);
    logic [7:0] codes [8] = '{8'hF0, 8'hE1, 8'hD2, 8'hB4, 8'h87, 8'hA5, 8'h96, 8'h78};
    logic [7:0] has_par = 8'b0110_1101;
    logic [7:0] is_line = 8'b0001_1111;

    ibc_sequencer #(.ADDR_HI(12)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_pins(addr_pins),
        .line_busy_flag(busy), .status_in(status_in), .read_data_in(read_data_in),
        .line_req_valid(req_valid), .line_req(line_req),
        .bridge_reset_pulse(rst_pulse), .config_byte(config_byte));
    ibc_host_model m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(m_low));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Line engine: busy from the cycle after a request for busy_len + 1 cycles.
    always @(posedge clk_sys) begin
        if (req_valid === 1'b1) begin
            n_req <= n_req + 1;
            last_req <= line_req;
            busy <= 1'b1;
            busy_cnt <= busy_len;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
        end else begin
            busy <= 1'b0;
        end
        if (rst_pulse === 1'b1) n_rst <= n_rst + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] c, output logic ack);
        logic a;
        m.start();
        m.write_byte({ADDR_HI, PINS, 1'b0}, a);
        check(a, 1'b1, "address ack");
        m.write_byte(c, ack);
    endtask

    task automatic rd(output logic [7:0] v);
        logic a;
        m.start();
        m.write_byte({ADDR_HI, PINS, 1'b1}, a);
        m.read_byte(v, 1'b0);
        m.stop();
    endtask

    // A host that does not poll simply waits out the line operation.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        check(busy, 1'b0, "line idle in time");
    endtask

    task automatic t_address();
        logic a;
        m.start();
        m.write_byte({ADDR_HI, ~PINS, 1'b0}, a);
        m.stop();
        check(a, 1'b0, "foreign address");
    endtask

    task automatic t_pointer();
        logic a;
        logic [7:0] v;
        cmd(ibc_pkg::CMD_POINTER_SELECT, a);
        m.write_byte(ibc_pkg::SEL_CONFIG, a);
        m.stop();
        check(a, 1'b1, "config selector");
        rd(v);
        check(v, ibc_pkg::CONFIG_RESET, "config read");
        rd(v);
        check(v, ibc_pkg::CONFIG_RESET, "pointer kept");
        cmd(ibc_pkg::CMD_POINTER_SELECT, a);
        m.write_byte(8'hE5, a);
        m.stop();
        check(a, 1'b0, "bad selector");
        rd(v);
        check(v, ibc_pkg::CONFIG_RESET, "pointer after refusal");
    endtask

    task automatic t_config();
        logic a;
        logic [7:0] v;
        cmd(ibc_pkg::CMD_CONFIG_WRITE, a);
        m.write_byte(8'h3C, a);
        check(a, 1'b1, "config byte ack");
        m.write_byte(8'h77, a);
        check(a, 1'b0, "extra byte");
        m.start();
        m.write_byte({ADDR_HI, PINS, 1'b1}, a);
        m.read_byte(v, 1'b0);
        m.stop();
        check(v, 8'h3C, "confirm read");
        check(config_byte, 8'h3C, "config output");
        cmd(8'h55, a);
        m.stop();
        check(a, 1'b0, "unknown code");
    endtask

    task automatic t_codes();
        logic a;
        int n0, r0;
        for (int i = 0; i < 8; i++) begin
            wait_idle();
            n0 = n_req;
            r0 = n_rst;
            cmd(codes[i], a);
            check(a, 1'b1, "command ack");
            if (has_par[7 - i]) begin
                m.write_byte(i == 1 ? ibc_pkg::SEL_STATUS : 8'h80, a);
                check(a, 1'b1, "parameter ack");
            end
            m.stop();
            check(n_req - n0, is_line[7 - i], "line request count");
            check(n_rst - r0, i == 0, "bridge reset pulse");
            if (is_line[7 - i]) check(last_req.code, codes[i], "line code");
        end
    endtask

    task automatic t_busy();
        logic a;
        logic [7:0] v;
        int n;
        wait_idle();
        busy_len = 12000;
        cmd(ibc_pkg::CMD_LINE_READ_BYTE, a);
        m.stop();
        check(a, 1'b1, "read byte ack");
        for (int i = 2; i < 8; i++) begin
            cmd(codes[i], a);
            m.stop();
            check(a, 1'b0, "busy refusal");
        end
        cmd(ibc_pkg::CMD_POINTER_SELECT, a);
        check(a, 1'b1, "select code while busy");
        m.write_byte(ibc_pkg::SEL_STATUS, a);
        check(a, 1'b1, "select while busy");
        m.start();
        m.write_byte({ADDR_HI, PINS, 1'b1}, a);
        m.read_byte(v, 1'b1);
        check(v, STAT | 8'h01, "busy status");
        n = 0;
        while (v[0] !== 1'b0 && n < 60) begin
            m.read_byte(v, 1'b1);
            n++;
        end
        check(n < 60, 1'b1, "poll ended in time");
        m.read_byte(v, 1'b0);
        m.stop();
        check(v, STAT, "status after poll");
        cmd(ibc_pkg::CMD_POINTER_SELECT, a);
        m.write_byte(ibc_pkg::SEL_READ_DATA, a);
        m.stop();
        rd(v);
        check(v, RDATA, "read data");
        busy_len = 100;
        cmd(ibc_pkg::CMD_SEARCH_TRIPLET, a);
        m.write_byte(8'h40, a);
        m.stop();
        check(a, 1'b1, "triplet parameter");
        check(last_req.param, 8'h40, "triplet request");
        wait_idle();
        cmd(ibc_pkg::CMD_POINTER_SELECT, a);
        m.write_byte(ibc_pkg::SEL_STATUS, a);
        m.stop();
        rd(v);
        check(v, STAT, "triplet outcome");
        cmd(ibc_pkg::CMD_LINE_RESET, a);
        m.stop();
        wait_idle();
        rd(v);
        check(v, STAT, "line reset outcome");
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        addr_pins = PINS;
        status_in = STAT;
        read_data_in = RDATA;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_address();
        t_pointer();
        t_config();
        t_codes();
        t_busy();
        end_of_test();
    end

    // The whole run needs about 0.53 ms; 1.5 ms leaves margin under the cycle cap.
    initial begin
        #1500000;
        n_errors++;
        end_of_test();
    end
endmodule
